// ---- rtl/touch_adc_params.svh ----
`ifndef TOUCH_ADC_PARAMS_SVH
`define TOUCH_ADC_PARAMS_SVH

// register location
`define CTRL_PAGE          1'h1
`define CTRL_ADDR          5'h00

// field positions
`define POS_PEN_MODE       15
`define POS_CONV_STATE     14
`define POS_FUNC_HI        13
`define POS_FUNC_LO        10
`define POS_RES_HI         9
`define POS_RES_LO         8

// reset values
`define RST_FUNC           4'h0
`define RST_RES            2'h0
`define RST_PEN_MODE       1'h0

// page 0 result register addresses
`define RES_X              5'h00
`define RES_Y              5'h01
`define RES_Z1             5'h02
`define RES_Z2             5'h03
`define RES_BAT1           5'h05
`define RES_BAT2           5'h06
`define RES_AUX1           5'h07
`define RES_AUX2           5'h08
`define RES_TEMP1          5'h09
`define RES_TEMP2          5'h0a

// function select codes with special meaning
`define FN_INVALID         4'h0
`define FN_SCAN_XY         4'h1
`define FN_SCAN_XYZ        4'h2
`define FN_DRIVE_X         4'hd
`define FN_DRIVE_Y         4'he
`define FN_DRIVE_YX        4'hf

`endif

// ---- rtl/touch_adc_pkg.sv ----
package touch_adc_pkg;
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_START,
        SEQ_WAIT,
        SEQ_STORE
    } seq_state_t;

    typedef logic [3:0] func_t;
    typedef logic [1:0] res_t;
    typedef logic [4:0] res_addr_t;
endpackage

// ---- rtl/sync_two_ff.sv ----
`timescale 1ns/10ps

module sync_two_ff #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             reset_n,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1;

    // stage1 is read by syncOut only
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stage1  <= '0;
            syncOut <= '0;
        end
        else if (ce)
        begin
            stage1  <= asyncIn;
            syncOut <= stage1;
        end
    end
endmodule

// ---- rtl/touch_adc_control.sv ----
`timescale 1ns/10ps
`include "touch_adc_params.svh"

module touch_adc_control
    import touch_adc_pkg::*;
(
    input  wire logic                      ref_clk,
    input  wire logic                      reset_n,
    input  wire logic                      ce,
    input  wire logic                      regWrEn,
    input  wire logic                      regPage,
    input  wire logic [4:0]                regAddr,
    input  wire logic [15:0]               regWrData,
    output logic      [15:0]               regRdData,
    input  wire logic                      penTouch,
    input  wire logic                      convDone,
    input  wire logic [11:0]               convData,
    output logic                           convStart,
    output logic                           convPowerDown,
    output touch_adc_pkg::res_t            convRes,
    output touch_adc_pkg::func_t           convFunc,
    output logic      [1:0]                panelDrive,
    output logic                           resultWrEn,
    output touch_adc_pkg::res_addr_t       resultAddr,
    output logic      [11:0]               resultData
);
    import touch_adc_pkg::*;

    seq_state_t state;
    func_t      func;
    res_t       res;
    logic       penMode;
    logic       penSync;
    logic       doneSync;
    logic       penPrev;
    logic       donePrev;
    logic [1:0] step;
    logic [11:0] dataHold;

    logic ctrlWr;
    logic stopWr;
    logic goWr;
    logic penRise;
    logic doneRise;
    logic busy;
    logic [2:0] stepCount;
    logic isScan;
    logic startReq;
    logic moreSteps;
    logic rescan;

    // converter strobe and pen detect come from the analog side
    sync_two_ff #(
        .WIDTH (2)
    ) u_sync (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .ce      (ce),
        .asyncIn ({penTouch, convDone}),
        .syncOut ({penSync, doneSync})
    );

    function automatic logic [2:0] steps_of(input func_t f);
        case (f)
            4'h1:    steps_of = 3'h2;
            4'h2:    steps_of = 3'h4;
            4'h5:    steps_of = 3'h2;
            4'hb:    steps_of = 3'h4;
            4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hc:
                     steps_of = 3'h1;
            default: steps_of = 3'h0;
        endcase
    endfunction

    function automatic res_addr_t addr_of(input func_t f,
                                          input logic [1:0] s);
        case (f)
            4'h1, 4'h2: addr_of = res_addr_t'(s);
            4'h3:    addr_of = `RES_X;
            4'h4:    addr_of = `RES_Y;
            4'h5:    addr_of = s[0] ? `RES_Z2 : `RES_Z1;
            4'h6:    addr_of = `RES_BAT1;
            4'h7:    addr_of = `RES_BAT2;
            4'h8:    addr_of = `RES_AUX1;
            4'h9:    addr_of = `RES_AUX2;
            4'ha:    addr_of = `RES_TEMP1;
            4'hb:    addr_of = `RES_BAT1 + res_addr_t'(s);
            4'hc:    addr_of = `RES_TEMP2;
            default: addr_of = `RES_X;
        endcase
    endfunction

    assign ctrlWr    = regWrEn && regPage == `CTRL_PAGE
                       && regAddr == `CTRL_ADDR;
    assign stopWr    = ctrlWr && regWrData[`POS_CONV_STATE];
    assign goWr      = ctrlWr && !regWrData[`POS_CONV_STATE];
    assign penRise   = penSync && !penPrev;
    assign doneRise  = doneSync && !donePrev;
    assign busy      = state != SEQ_IDLE;
    assign stepCount = steps_of(func);
    assign isScan    = func == `FN_SCAN_XY || func == `FN_SCAN_XYZ;
    assign moreSteps = {1'b0, step} + 3'h1 < stepCount;
    assign rescan    = isScan && penSync && !convPowerDown;
    // host mode starts on the write, judged by the code being written,
    // so a start from code 0 is not lost; touch mode waits for the pen
    assign startReq  = !busy
                       && ((goWr && !regWrData[`POS_PEN_MODE]
                            && steps_of(regWrData[`POS_FUNC_HI:`POS_FUNC_LO])
                               != 3'h0)
                           || (penMode && penRise && !convPowerDown
                               && stepCount != 3'h0));

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            penPrev  <= 1'b0;
            donePrev <= 1'b0;
        end
        else if (ce)
        begin
            penPrev  <= penSync;
            donePrev <= doneSync;
        end
    end

    // register fields
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            func    <= `RST_FUNC;
            res     <= `RST_RES;
            penMode <= `RST_PEN_MODE;
        end
        else if (ce && ctrlWr)
        begin
            func    <= regWrData[`POS_FUNC_HI:`POS_FUNC_LO];
            res     <= regWrData[`POS_RES_HI:`POS_RES_LO];
            penMode <= regWrData[`POS_PEN_MODE];
        end
    end

    // power down holds until the next write of 0 to the state bit
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            convPowerDown <= 1'b0;
        else if (ce)
        begin
            if (stopWr)
                convPowerDown <= 1'b1;
            else if (goWr)
                convPowerDown <= 1'b0;
        end
    end

    // conversion sequencer
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state      <= SEQ_IDLE;
            step       <= 2'h0;
            convStart  <= 1'b0;
            resultWrEn <= 1'b0;
            resultAddr <= `RES_X;
            resultData <= 12'h000;
            dataHold   <= 12'h000;
        end
        else if (ce)
        begin
            convStart  <= 1'b0;
            resultWrEn <= 1'b0;
            if (stopWr)
            begin
                state <= SEQ_IDLE;
                step  <= 2'h0;
            end
            else
            begin
                case (state)
                    SEQ_IDLE:
                    begin
                        step <= 2'h0;
                        if (startReq)
                            state <= SEQ_START;
                    end
                    SEQ_START:
                    begin
                        convStart <= 1'b1;
                        state     <= SEQ_WAIT;
                    end
                    SEQ_WAIT:
                    begin
                        if (doneRise)
                        begin
                            dataHold <= convData;
                            state    <= SEQ_STORE;
                        end
                    end
                    SEQ_STORE:
                    begin
                        resultWrEn <= 1'b1;
                        resultAddr <= addr_of(func, step);
                        resultData <= dataHold;
                        if (moreSteps)
                        begin
                            step  <= step + 2'h1;
                            state <= SEQ_START;
                        end
                        else if (rescan)
                        begin
                            step  <= 2'h0;
                            state <= SEQ_START;
                        end
                        else
                            state <= SEQ_IDLE;
                    end
                    default:
                        state <= SEQ_IDLE;
                endcase
            end
        end
    end

    // readback and drive outputs, all registered
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            regRdData  <= 16'h4000;
            convRes    <= `RST_RES;
            convFunc   <= `RST_FUNC;
            panelDrive <= 2'h0;
        end
        else if (ce)
        begin
            regRdData  <= {penSync, !busy, func, res, 8'h00};
            convRes    <= res;
            convFunc   <= func;
            // driver-only codes hold the panel; off while powered down
            if (convPowerDown || func < `FN_DRIVE_X)
                panelDrive <= 2'h0;
            else
                panelDrive <= 2'(func - `FN_DRIVE_X + 4'h1);
        end
    end

    a_pen_readback: assert property (@(posedge ref_clk) disable iff (!reset_n)
        ce |=> regRdData[`POS_PEN_MODE] == $past(penSync))
        else $error("pen bit does not follow touch");

    a_busy_readback: assert property (@(posedge ref_clk)
        disable iff (!reset_n)
        ce && state == SEQ_WAIT |=> !regRdData[`POS_CONV_STATE])
        else $error("state bit not 0 while busy");

    a_stop_abort: assert property (@(posedge ref_clk) disable iff (!reset_n)
        ce && stopWr |=> state == SEQ_IDLE && convPowerDown
                         && !convStart)
        else $error("stop write did not abort");

    a_rescan_loop: assert property (@(posedge ref_clk)
        disable iff (!reset_n)
        ce && state == SEQ_STORE && !moreSteps && rescan && !stopWr
        |=> state == SEQ_START && step == 2'h0)
        else $error("scan did not repeat");

    a_field_write: assert property (@(posedge ref_clk)
        disable iff (!reset_n)
        ce && ctrlWr |=> func == $past(regWrData[13:10])
                         && res == $past(regWrData[9:8])
                         && penMode == $past(regWrData[15]))
        else $error("fields did not take write");

    a_result_slot: assert property (@(posedge ref_clk)
        disable iff (!reset_n)
        ce && state == SEQ_STORE && !stopWr
        |=> resultWrEn && resultAddr == addr_of($past(func), $past(step)))
        else $error("result written to wrong slot");

    a_invalid_quiet: assert property (@(posedge ref_clk)
        disable iff (!reset_n)
        ce && func == `FN_INVALID && state == SEQ_IDLE |=> !resultWrEn)
        else $error("invalid code updated a result");

    a_touch_start: assert property (@(posedge ref_clk)
        disable iff (!reset_n)
        ce && penMode && penRise && !busy && stepCount != 3'h0
        && !convPowerDown && !ctrlWr
        |=> state == SEQ_START ##1 convStart)
        else $error("touch did not start conversion");
endmodule

// ---- test/converter_model.sv ----
`timescale 1ns/10ps

module converter_model (
    input  wire logic        ref_clk,
    input  wire logic        convStart,
    input  wire logic        convPowerDown,
    input  wire logic [31:0] dly,
    output logic             convDone,
    output logic [11:0]      convData,
    output logic [11:0]      sent
);
    int starts = 0;
    int served = 0;

    always @(posedge ref_clk)
    begin
        if (convStart === 1'b1)
            starts <= starts + 1;
    end

    // data is inverted outside the hold span so stale values never match
    initial
    begin
        convDone = 1'b0;
        sent = 12'h5a0;
        convData = ~sent;
        forever
        begin
            @(posedge ref_clk);
            #3;
            if (convPowerDown === 1'b1)
                served = starts;
            else if (served != starts)
            begin
                served++;
                repeat (dly) @(posedge ref_clk);
                #3;
                sent = sent + 12'h013;
                convData = sent;
                convDone = 1'b1;
                repeat (5) @(posedge ref_clk);
                #3;
                convDone = 1'b0;
                convData = ~sent;
            end
        end
    end
endmodule

// ---- test/touch_adc_control_test.sv ----
`timescale 1ns/10ps
`include "touch_adc_params.svh"

module touch_adc_control_test;
    import touch_adc_pkg::*;
    logic ref_clk = 0, reset_n = 0, ce = 1, regWrEn = 0, regPage = 0;
    logic [4:0] regAddr = 0;
    logic [15:0] regWrData = 0, regRdData;
    logic penTouch = 0, convDone, convStart, convPowerDown;
    logic [11:0] convData, resultData, sent;
    res_t convRes;
    func_t convFunc;
    logic [1:0] panelDrive;
    logic resultWrEn;
    res_addr_t resultAddr, q[$];
    int dly = 2, n_errors = 0, n_tests = 0;
    logic [15:0] rowWr [6] = '{16'h0000, 16'h3500, 16'h3a00, 16'h3f00,
                               16'h7cff, 16'h4400};
    logic [15:0] rowRd [6] = '{16'h4000, 16'h7500, 16'h7a00, 16'h7f00,
                               16'h7c00, 16'h4400};
    logic [1:0] rowDrv [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
    func_t fnCode [8] = '{4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hc};
    res_addr_t fnAddr [8] = '{`RES_X, `RES_Y, `RES_BAT1, `RES_BAT2,
                              `RES_AUX1, `RES_AUX2, `RES_TEMP1, `RES_TEMP2};

    always #12.5 ref_clk = ~ref_clk;

    touch_adc_control i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .ce(ce),
        .regWrEn(regWrEn), .regPage(regPage), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData), .penTouch(penTouch),
        .convDone(convDone), .convData(convData), .convStart(convStart),
        .convPowerDown(convPowerDown), .convRes(convRes),
        .convFunc(convFunc), .panelDrive(panelDrive),
        .resultWrEn(resultWrEn), .resultAddr(resultAddr),
        .resultData(resultData));

    converter_model i_conv (.ref_clk(ref_clk), .convStart(convStart),
        .convPowerDown(convPowerDown), .dly(dly), .convDone(convDone),
        .convData(convData), .sent(sent));

    task automatic chk(input string nm, input logic [15:0] e, g);
        n_tests++;
        if (g !== e)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic tick(input int n = 1);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask

    task automatic wr(input logic p, input logic [4:0] a,
                      input logic [15:0] d);
        regPage = p;
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        tick();
        regWrEn = 1'b0;
    endtask

    task automatic waitq(input int n);
        for (int i = 0; i < 400 && q.size() < n; i++)
            tick();
        chk("resultCount", 16'(n), 16'(q.size()));
    endtask

    // runs one host-started sequence and checks the slots it writes
    task automatic runfn(input func_t f, input int n, input logic [19:0] a);
        q.delete();
        wr(1'b1, `CTRL_ADDR, {2'b00, f, 10'h000});
        tick(2);
        chk("busyBit", 16'h0, {15'h0, regRdData[14]});
        waitq(n);
        for (int i = 0; i < n; i++)
            chk("resultAddr", {11'h0, a[i*5+:5]}, {11'h0, q[i]});
        tick(8);
        chk("doneBit", 16'h1, {15'h0, regRdData[14]});
    endtask

    always @(posedge ref_clk)
    begin
        if (resultWrEn === 1'b1)
        begin
            q.push_back(resultAddr);
            chk("resultData", {4'h0, sent}, {4'h0, resultData});
        end
    end

    initial
    begin
        #300000;
        n_errors++;
        stop_test();
    end

    initial
    begin
        tick(2);
        chk("resetRead", 16'h4000, regRdData);
        reset_n = 1'b1;
        tick();
        chk("resetPower", 16'h0, {15'h0, convPowerDown});
        for (int r = 0; r < 6; r++)
        begin
            wr(1'b1, `CTRL_ADDR, rowWr[r]);
            tick(2);
            chk("readBack", rowRd[r], regRdData);
            chk("fields", rowWr[r][13:8], {convFunc, convRes});
            chk("panelDrive", {14'h0, rowDrv[r]}, {14'h0, panelDrive});
            chk("powerDown", {15'h0, rowWr[r][14]}, {15'h0, convPowerDown});
        end
        wr(1'b0, `CTRL_ADDR, 16'h0b00);
        tick();
        wr(1'b1, 5'h01, 16'h0b00);
        tick(2);
        chk("otherRegs", 16'h4400, regRdData);
        runfn(4'h2, 4, {5'h03, 5'h02, 5'h01, 5'h00});
        runfn(4'h1, 2, {10'h0, 5'h01, 5'h00});
        runfn(4'h5, 2, {10'h0, 5'h03, 5'h02});
        runfn(4'hb, 4, {5'h08, 5'h07, 5'h06, 5'h05});
        dly = 9;
        for (int i = 0; i < 8; i++)
            runfn(fnCode[i], 1, {15'h0, fnAddr[i]});
        // stop in mid-sequence, then function code 0
        q.delete();
        wr(1'b1, `CTRL_ADDR, 16'h0800);
        for (int i = 0; i < 20 && convStart !== 1'b1; i++)
            tick();
        chk("startPulse", 16'h1, {15'h0, convStart});
        tick();
        chk("startEnd", 16'h0, {15'h0, convStart});
        wr(1'b1, `CTRL_ADDR, 16'h4800);
        tick();
        chk("stopPower", 16'h1, {15'h0, convPowerDown});
        tick(60);
        chk("stopResults", 16'h0, 16'(q.size()));
        chk("stopRead", 16'h4800, regRdData);
        wr(1'b1, `CTRL_ADDR, 16'h0000);
        tick(40);
        chk("invalidFn", 16'h0, 16'(q.size()));
        // device-run scans
        dly = 2;
        wr(1'b1, `CTRL_ADDR, 16'h8400);
        tick(20);
        chk("noWriteStart", 16'h0, 16'(q.size()));
        penTouch = 1'b1;
        waitq(6);
        chk("penRead", 16'h1, {15'h0, regRdData[15]});
        chk("scanAddr", 16'h0, {11'h0, q[2]});
        penTouch = 1'b0;
        tick(40);
        q.delete();
        tick(40);
        chk("penLift", 16'h0, 16'(q.size()));
        chk("penIdle", 16'h0, {15'h0, regRdData[15]});
        // reset again while idle after pen lift, with fields and mode set
        reset_n = 1'b0;
        tick();
        chk("midReset", 16'h4000, regRdData);
        chk("midResetFn", 16'h0, {10'h0, convFunc, convRes});
        reset_n = 1'b1;
        tick(2);
        chk("afterReset", 16'h4000, regRdData);
        stop_test();
    end
endmodule
